// ---- include/ldsr_pkg.sv ----
// Purpose: Shared constants for the LED driver serial register block
// Assumes: 24-bit configuration word, 24-bit fault readback word
// Notes: Offsets are register indices on the serial interface
package ldsr_pkg;
    localparam int CFG_W = 24;
    localparam int CRC_W = 6;
    localparam int NPAIR = 8;
    localparam int NCHAN = 16;
    localparam logic [6:0] CRC_POLY = 7'h43;
    localparam logic [0:0] OUTPUT_CONFIG_OFS = 1'h0;
    localparam logic [0:0] FAULT_STATUS_OFS = 1'h1;
    localparam logic [23:0] OUTPUT_CONFIG_RST = 24'h000000;
    localparam logic [23:0] FAULT_STATUS_RST = 24'h000000;
    localparam logic [5:0] CRC_RST = 6'h00;
    localparam int CFG_DIAG_LSB = 16;
    localparam int RB_FLAG_LSB = 8;
    localparam int RB_OT_BIT = 7;
    localparam int RB_CONFLICT_BIT = 6;
    localparam int SYNC_STAGES = 2;
endpackage

// ---- include/ldsr_core_if.sv ----
// Purpose: Carrier between the register core, checksum and fault flag modules
// Assumes: All signals on the core clock
// Notes: Conditions are already synchronised by the core
`timescale 1ns/10ps
interface ldsr_core_if;
    logic [23:0] cfg_word;
    logic [5:0] crc_rem;
    logic [7:0] open_cond;
    logic [7:0] short_cond;
    logic ot_cond;
    logic conflict_cond;
    logic rd_clr;
    logic dflt;
    logic [7:0] open_flag;
    logic [7:0] short_flag;
    logic ot_flag;
    logic conflict_flag;
    modport crc_mp(input cfg_word, output crc_rem);
    modport flt_mp(input open_cond, short_cond, ot_cond, conflict_cond, rd_clr, dflt,
                   output open_flag, short_flag, ot_flag, conflict_flag);
    modport ctl_mp(output cfg_word, open_cond, short_cond, ot_cond, conflict_cond, rd_clr, dflt,
                   input crc_rem, open_flag, short_flag, ot_flag, conflict_flag);
endinterface

// ---- rtl/ldsr_crc.sv ----
// Purpose: Six-bit checksum remainder of the configuration word
// Assumes: Purely combinational, word stable while it is sampled
// Notes: Shift-register form, equal to dividing the word padded with six zeros
`timescale 1ns/10ps
module ldsr_crc (
    ldsr_core_if.crc_mp core
);
    logic [5:0] chain [0:24];
    assign chain[0] = ldsr_pkg::CRC_RST;
    genvar i;
    generate
        for (i = 0; i < ldsr_pkg::CFG_W; i++) begin : g_step
            logic fb;
            assign fb = chain[i][5] ^ core.cfg_word[ldsr_pkg::CFG_W - 1 - i];
            assign chain[i + 1] = {chain[i][4:0], 1'b0} ^ (fb ? ldsr_pkg::CRC_POLY[5:0] : 6'h00);
        end
    endgenerate
    assign core.crc_rem = chain[24];
endmodule

// ---- rtl/ldsr_fault.sv ----
// Purpose: Sticky read-to-clear fault flags
// Assumes: rd_clr is a one-cycle pulse at the readback load
// Notes: A fault present during a readback survives it
`timescale 1ns/10ps
module ldsr_fault (
    input wire logic clk,
    input wire logic rst_n,
    ldsr_core_if.flt_mp core
);
    // Overtemp, conflict, eight open and eight short flags
    localparam int NFLAG = 18;
    logic [NFLAG-1:0] cond;
    logic [NFLAG-1:0] flag_r;
    logic [NFLAG-1:0] flag_nxt;
    assign cond = {core.ot_cond, core.conflict_cond, core.open_cond, core.short_cond};
    genvar i;
    generate
        for (i = 0; i < NFLAG; i++) begin : g_flag
            assign flag_nxt[i] = cond[i] | (flag_r[i] & ~(core.rd_clr & ~cond[i]));
        end
    endgenerate
    always_ff @(posedge clk) begin
        if (!rst_n || core.dflt) begin
            flag_r <= 18'h00000;
        end else begin
            flag_r <= flag_nxt;
        end
    end
    assign core.ot_flag = flag_r[17];
    assign core.conflict_flag = flag_r[16];
    assign core.open_flag = flag_r[15:8];
    assign core.short_flag = flag_r[7:0];
    rd_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        (core.rd_clr && !core.dflt && cond == 18'h00000) |=> flag_r == 18'h00000)
        else $error("flag not cleared by readback");
    flag_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        (core.rd_clr && !core.dflt) |=> ((flag_r & $past(cond)) == $past(cond)))
        else $error("present fault lost at readback");
    flag_sticky_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!core.rd_clr && !core.dflt) |=> ((flag_r & $past(flag_r)) == $past(flag_r)))
        else $error("flag dropped without readback");
endmodule

// ---- rtl/ldsr_top.sv ----
// Purpose: Register side of a 16-channel LED driver with serial shift interface
// Assumes: All pins asynchronous to clk, sampled through two flip-flops
// Notes: Pin clocks are edge-detected; they must stay well below clk/4
// Functional notes
// - Checksum divides the 24-bit word, padded with six zeros, by the generator.
// - Generator polynomial has bits 6, 1 and 0 set.
// - Readback word carries the 6-bit checksum remainder.
// - Checksum computation leaves the shift register untouched.
// - Each latched word is checked for illegal command combinations.
// - Clear pin low clears configuration and fault state.
// - Latch clock rising edge loads the storage register.
// - Switches follow storage only while their group gate is low.
// - Power-on reset starts everything from defaults.
// - Enable pin high forces standby and default registers.
// - Bits 23..16 select diagnostics mode per channel pair.
// - Fault flags clear on readback once the fault has gone.
// - All fields are zero after reset or default entry.
// - Bits 15..0 switch the same-numbered channel on when high.
// - Diagnostics plus odd output high runs plain output and flags conflict.
// - Data shifts in on shift clock rise, captured on latch rise.
// - Latch rise loads fault word, msb first, shifted out on shift fall.
`timescale 1ns/10ps
module ldsr_top (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic serial_in,
    input wire logic shift_clock,
    input wire logic latch_clock,
    input wire logic register_clear_n,
    input wire logic chip_enable_n,
    input wire logic group_low_gate_n,
    input wire logic group_high_gate_n,
    input wire logic [7:0] open_detect,
    input wire logic [7:0] short_detect,
    input wire logic overtemp_detect,
    output logic serial_out,
    output logic [15:0] output_switch,
    output logic [7:0] sense_select,
    output logic fault_pull_o,
    output logic fault_pull_oe
);
    localparam int SYNC_W = 24;

    ldsr_core_if core ();

    logic [SYNC_W-1:0] pins;
    logic [SYNC_W-1:0] sync1_r;
    logic [SYNC_W-1:0] sync2_r;
    logic sdi_s;
    logic sck_s;
    logic lck_s;
    logic clr_n_s;
    logic en_n_s;
    logic g_lo_n_s;
    logic g_hi_n_s;
    logic [7:0] open_s;
    logic [7:0] short_s;
    logic ot_s;
    logic sck_prev_r;
    logic lck_prev_r;
    logic sck_rise;
    logic sck_fall;
    logic lck_rise;
    logic dflt;
    logic [23:0] sr_r;
    logic [23:0] store_r;
    logic [5:0] crc_r;
    logic [23:0] rb_r;
    logic [23:0] rb_word;
    logic [15:0] flag_pairs;
    logic [15:0] switch_nxt;
    logic [7:0] sense_nxt;
    logic [7:0] conflict_pair;
    logic [15:0] switch_r;
    logic [7:0] sense_r;
    logic fault_any_r;

    assign pins = {overtemp_detect, short_detect, open_detect, group_high_gate_n, group_low_gate_n,
                   chip_enable_n, register_clear_n, latch_clock, shift_clock, serial_in};

    // Two-stage synchroniser for every pin; only the second stage is read
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync1_r <= 24'h000000;
            sync2_r <= 24'h000000;
        end else begin
            sync1_r <= pins;
            sync2_r <= sync1_r;
        end
    end

    assign sdi_s = sync2_r[0];
    assign sck_s = sync2_r[1];
    assign lck_s = sync2_r[2];
    assign clr_n_s = sync2_r[3];
    assign en_n_s = sync2_r[4];
    assign g_lo_n_s = sync2_r[5];
    assign g_hi_n_s = sync2_r[6];
    assign open_s = sync2_r[14:7];
    assign short_s = sync2_r[22:15];
    assign ot_s = sync2_r[23];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sck_prev_r <= 1'b0;
            lck_prev_r <= 1'b0;
        end else begin
            sck_prev_r <= sck_s;
            lck_prev_r <= lck_s;
        end
    end

    assign sck_rise = sck_s & ~sck_prev_r;
    assign sck_fall = ~sck_s & sck_prev_r;
    assign lck_rise = lck_s & ~lck_prev_r;

    assign dflt = ~clr_n_s | en_n_s;

    always_ff @(posedge clk) begin
        if (!rst_n || dflt) begin
            sr_r <= ldsr_pkg::OUTPUT_CONFIG_RST;
        end else if (sck_rise) begin
            sr_r <= {sr_r[22:0], sdi_s};
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || dflt) begin
            store_r <= ldsr_pkg::OUTPUT_CONFIG_RST;
            crc_r <= ldsr_pkg::CRC_RST;
        end else if (lck_rise) begin
            store_r <= sr_r;
            crc_r <= core.crc_rem;
        end
    end

    assign core.cfg_word = sr_r;

    ldsr_crc u_crc (
        .core(core.crc_mp)
    );

    genvar p;
    generate
        for (p = 0; p < ldsr_pkg::NPAIR; p++) begin : g_pair
            assign conflict_pair[p] = store_r[ldsr_pkg::CFG_DIAG_LSB + p] & store_r[2*p + 1];
            assign sense_nxt[p] = store_r[ldsr_pkg::CFG_DIAG_LSB + p] & ~store_r[2*p + 1];
            // Sense only meaningful while the driven channel is on
            assign core.open_cond[p] = open_s[p] & sense_r[p] & switch_r[2*p];
            assign core.short_cond[p] = short_s[p] & sense_r[p] & switch_r[2*p];
            assign flag_pairs[2*p + 1] = core.open_flag[p];
            assign flag_pairs[2*p] = core.short_flag[p];
        end
    endgenerate

    assign core.conflict_cond = |conflict_pair;
    assign core.ot_cond = ot_s;
    assign core.dflt = dflt;
    assign core.rd_clr = lck_rise;

    ldsr_fault u_fault (
        .clk(clk),
        .rst_n(rst_n),
        .core(core.flt_mp)
    );

    // group gating
    // Overtemperature turns every channel off regardless of configuration
    assign switch_nxt = store_r[15:0] & {{8{~g_hi_n_s}}, {8{~g_lo_n_s}}} & {16{~ot_s}};

    always_ff @(posedge clk) begin
        if (!rst_n || dflt) begin
            switch_r <= 16'h0000;
            sense_r <= 8'h00;
        end else begin
            switch_r <= switch_nxt;
            sense_r <= sense_nxt;
        end
    end

    assign rb_word = {flag_pairs, core.ot_flag, core.conflict_flag, core.crc_rem};

    always_ff @(posedge clk) begin
        if (!rst_n || dflt) begin
            rb_r <= ldsr_pkg::FAULT_STATUS_RST;
        end else if (lck_rise) begin
            rb_r <= rb_word;
        end else if (sck_fall) begin
            rb_r <= {rb_r[22:0], 1'b0};
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fault_any_r <= 1'b0;
        end else begin
            fault_any_r <= |rb_word[23:6];
        end
    end

    assign serial_out = rb_r[23];
    assign output_switch = switch_r;
    assign sense_select = sense_r;
    // Open-drain error line: pulled low while any flag stands
    assign fault_pull_o = 1'b0;
    assign fault_pull_oe = fault_any_r;

    // Long division used only by the checks below
    function automatic logic [5:0] ldsr_residual(input logic [29:0] v);
        logic [29:0] t;
        t = v;
        for (int i = 29; i >= 6; i--) begin
            if (t[i]) begin
                t[i -: 7] = t[i -: 7] ^ ldsr_pkg::CRC_POLY;
            end
        end
        return t[5:0];
    endfunction

    crc_residual_a: assert property (@(posedge clk) disable iff (!rst_n)
        ldsr_residual({store_r, crc_r}) == 6'h00)
        else $error("stored checksum does not divide out");
    rb_crc_a: assert property (@(posedge clk) disable iff (!rst_n)
        (lck_rise && !dflt) |=> (rb_r[5:0] == crc_r))
        else $error("readback remainder mismatch");
    sr_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
        (lck_rise && !sck_rise && !dflt) |=> (sr_r == $past(sr_r)))
        else $error("shift register altered by latch");
    latch_cap_a: assert property (@(posedge clk) disable iff (!rst_n)
        (lck_rise && !dflt) |=> (store_r == $past(sr_r)))
        else $error("storage did not capture shift word");
    conflict_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        (core.conflict_cond && !dflt) |=> core.conflict_flag)
        else $error("conflict not flagged");
    clear_all_a: assert property (@(posedge clk) disable iff (!rst_n)
        dflt |=> (store_r == 24'h000000 && rb_r == 24'h000000 && switch_r == 16'h0000))
        else $error("default state not cleared");
    gate_low_a: assert property (@(posedge clk) disable iff (!rst_n)
        (g_lo_n_s || ot_s) |=> (switch_r[7:0] == 8'h00))
        else $error("low group driven while gated");
    switch_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!dflt && !g_lo_n_s && !g_hi_n_s && !ot_s) |=> (switch_r == $past(store_r[15:0])))
        else $error("switches not following storage");
    sense_sel_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!dflt) |=> ((sense_r & $past(conflict_pair)) == 8'h00))
        else $error("sense select active during conflict");
    serial_out_a: assert property (@(posedge clk) disable iff (!rst_n)
        (sck_fall && !lck_rise && !dflt) |=> (serial_out == $past(rb_r[22])))
        else $error("serial out did not advance");

    gate_high_a: assert property (@(posedge clk) disable iff (!rst_n)
        (g_hi_n_s || ot_s) |=> (switch_r[15:8] == 8'h00))
        else $error("high group driven while gated");
    shift_in_a: assert property (@(posedge clk) disable iff (!rst_n)
        (sck_rise && !dflt) |=> (sr_r == {$past(sr_r[22:0]), $past(sdi_s)}))
        else $error("shift register did not take data bit");
    rb_low_a: assert property (@(posedge clk) disable iff (!rst_n)
        (lck_rise && !dflt) |=> (rb_r[7] == $past(core.ot_flag) && rb_r[6] == $past(core.conflict_flag)))
        else $error("readback flag bits misplaced");
    rb_pair_a: assert property (@(posedge clk) disable iff (!rst_n)
        (lck_rise && !dflt) |=> (rb_r[9] == $past(core.open_flag[0]) && rb_r[8] == $past(core.short_flag[0])))
        else $error("readback pair zero misplaced");
    rb_top_a: assert property (@(posedge clk) disable iff (!rst_n)
        (lck_rise && !dflt) |=> (rb_r[23] == $past(core.open_flag[7]) && rb_r[22] == $past(core.short_flag[7])))
        else $error("readback pair seven misplaced");
    reset_clear_a: assert property (@(posedge clk)
        !rst_n |=> (store_r == 24'h000000 && sr_r == 24'h000000 && switch_r == 16'h0000 && sense_r == 8'h00))
        else $error("registers not cleared by reset");
    standby_a: assert property (@(posedge clk) disable iff (!rst_n)
        en_n_s |=> (sr_r == 24'h000000 && sense_r == 8'h00 && crc_r == 6'h00))
        else $error("standby did not restore defaults");
    clr_flags_a: assert property (@(posedge clk) disable iff (!rst_n)
        !clr_n_s |=> (core.open_flag == 8'h00 && core.short_flag == 8'h00 && !core.ot_flag && !core.conflict_flag))
        else $error("clear pin left a fault flag");
    zero_out_a: assert property (@(posedge clk) disable iff (!rst_n)
        dflt |=> (serial_out == 1'b0 && output_switch == 16'h0000 && sense_select == 8'h00))
        else $error("outputs not zero in default state");
    store_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!lck_rise && !dflt) |=> (store_r == $past(store_r)))
        else $error("storage changed without latch");
    pair_sense_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!dflt) |=> (sense_r[0] == ($past(store_r[16]) && !$past(store_r[1]))
            && sense_r[7] == ($past(store_r[23]) && !$past(store_r[15]))))
        else $error("pair sense select wrong");
    odd_plain_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!dflt && !g_lo_n_s && !ot_s && store_r[16] && store_r[1]) |=> switch_r[1])
        else $error("conflicting odd channel not driven");
    crc_live_a: assert property (@(posedge clk) disable iff (!rst_n)
        ldsr_residual({sr_r, core.crc_rem}) == 6'h00)
        else $error("live checksum does not divide out");
    ser_first_a: assert property (@(posedge clk) disable iff (!rst_n)
        (lck_rise && !dflt) |=> (serial_out == $past(rb_word[23])))
        else $error("readback msb not on serial out");
endmodule

// ---- sim/ldsr_host.sv ----
// Purpose: Host model driving the serial shift and latch pins
// Assumes: Link clock half period of four core cycles, idle low between frames
// Notes: Readback bits are sampled just before each shift fall
`timescale 1ns/10ps
module ldsr_host (
    input wire logic clk,
    input wire logic serial_out,
    output logic serial_in,
    output logic shift_clock,
    output logic latch_clock,
    output logic [23:0] rb_word,
    output logic rb_done
);
    initial begin
        serial_in = 1'b0;
        shift_clock = 1'b0;
        latch_clock = 1'b0;
        rb_word = 24'h000000;
        rb_done = 1'b0;
    end
    task automatic tk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic xfer(input logic [23:0] w);
        for (int i = 23; i >= 0; i--) begin
            serial_in = w[i];
            tk(4);
            shift_clock = 1'b1;
            tk(4);
            rb_word[i] = serial_out;
            shift_clock = 1'b0;
        end
        rb_done = 1'b1;
        tk(1);
        rb_done = 1'b0;
        // Released data line shows the inverse so a stale sample cannot pass
        serial_in = ~serial_in;
        latch_clock = 1'b1;
        tk(4);
        latch_clock = 1'b0;
        tk(4);
    endtask
endmodule

// ---- sim/tb_ldsr_top.sv ----
// Purpose: Self-checking bench for the LED driver register block
// Assumes: Host model owns the link pins, bench owns the rest
// Notes: Readback of frame k is the fault word latched at the end of frame k-1
`timescale 1ns/10ps
module tb_ldsr_top;
    logic clk, rst_n, serial_out, fault_pull_o, fault_pull_oe, clr_n, ce_n, gl, gh, ot, rb_done;
    logic serial_in, shift_clock, latch_clock;
    logic [7:0] opn, sht, sense_select;
    logic [15:0] output_switch;
    logic [23:0] rb_word, pend, lastw, h1, h2, seen, q[$], qw[$];
    int err_count, n_tests, cyc, seed;
    ldsr_top uut (.clk(clk), .rst_n(rst_n), .serial_in(serial_in), .shift_clock(shift_clock),
        .latch_clock(latch_clock), .register_clear_n(clr_n), .chip_enable_n(ce_n),
        .group_low_gate_n(gl), .group_high_gate_n(gh), .open_detect(opn), .short_detect(sht),
        .overtemp_detect(ot), .serial_out(serial_out), .output_switch(output_switch),
        .sense_select(sense_select), .fault_pull_o(fault_pull_o), .fault_pull_oe(fault_pull_oe));
    ldsr_host host (.clk(clk), .serial_out(serial_out), .serial_in(serial_in), .shift_clock(shift_clock),
        .latch_clock(latch_clock), .rb_word(rb_word), .rb_done(rb_done));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic tk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    function automatic logic [5:0] rem30(input logic [29:0] v);
        for (int i = 29; i >= 6; i--) if (v[i]) v[i -: 7] = v[i -: 7] ^ ldsr_pkg::CRC_POLY;
        return v[5:0];
    endfunction
    function automatic logic [7:0] od(input logic [23:0] w);
        for (int p = 0; p < 8; p++) od[p] = w[2 * p + 1];
    endfunction
    task automatic chk_pin(input logic [23:0] got, input logic [23:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_rb(input logic [23:0] got, input logic [23:0] exp, input logic [23:0] w);
        chk_pin(got, exp);
        chk_pin({18'h0, rem30({w, got[5:0]})}, 24'h000000);
    endtask
    task automatic ck_out();
        chk_pin({8'h0, output_switch}, {8'h0, h1[15:0] & {{8{~gh}}, {8{~gl}}}});
        chk_pin({16'h0, sense_select}, {16'h0, h1[23:16] & ~od(h1)});
    endtask
    task automatic wr(input logic [23:0] w);
        q.push_back(pend);
        qw.push_back(lastw);
        host.xfer(w);
        // Conflict of the two previous stores stands at this latch
        pend = {seen[23:7], |(h1[23:16] & od(h1)) | |(h2[23:16] & od(h2)), rem30({w, 6'h00})};
        seen = 24'h000000;
        h2 = h1;
        h1 = w;
        lastw = w;
        tk(2);
        ck_out();
    endtask
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    always @(posedge rb_done) begin
        chk_rb(rb_word, q.pop_front(), qw.pop_front());
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            give_verdict();
        end
    end
    initial begin
        seed = 36302;
        {rst_n, gl, gh, ot, ce_n, clr_n} = 6'h00;
        {opn, sht} = 16'h0000;
        {pend, lastw, h1, h2, seen} = '0;
        repeat (10) @(posedge clk);
        #1 rst_n = 1'b1;
        tk(4);
        ck_out();
        clr_n = 1'b1;
        tk(4);
        wr(24'hd70f68);
        for (int i = 0; i < 6; i++) wr(24'($random(seed)));
        for (int g = 0; g < 4; g++) begin
            {gh, gl} = 2'(g);
            tk(6);
            ck_out();
        end
        {gh, gl} = 2'b00;
        wr(24'h010001);
        for (int k = 0; k < 3; k++) begin
            {sht[0], opn[0], ot} = 3'(1 << k);
            tk(10);
            chk_pin({22'h0, fault_pull_o, fault_pull_oe}, 24'h000001);
            if (k == 0) chk_pin({8'h0, output_switch}, 24'h000000);
            {sht[0], opn[0], ot} = 3'b000;
            seen[k == 0 ? 7 : (k == 1 ? 9 : 8)] = 1'b1;
            tk(10);
            wr(24'h010001);
        end
        wr(24'h808000);
        wr(24'h000000);
        for (int m = 0; m < 2; m++) begin
            wr(24'h808000 | 24'($random(seed)));
            if (m == 0) clr_n = 1'b0;
            else ce_n = 1'b1;
            {pend, lastw, h1, h2, seen} = '0;
            tk(8);
            ck_out();
            chk_pin({22'h0, fault_pull_o, fault_pull_oe}, 24'h000000);
            {clr_n, ce_n} = 2'b10;
            tk(4);
        end
        wr(24'h000000);
        give_verdict();
    end
endmodule
